// >>> include/tce_map.svh
// constants of the contactless tag command engine
`ifndef TCE_MAP_SVH
`define TCE_MAP_SVH

// command codes
`define TCE_CMD_INVENTORY 8'h06
`define TCE_SUB_OPEN 8'h00
`define TCE_SUB_POLL 8'h04
`define TCE_PROBE_CODE 4'h6
`define TCE_CMD_FETCH 8'h08
`define TCE_CMD_CENSUS 8'h0c
`define TCE_CMD_SELECT 8'h0e
`define TCE_CMD_FINISH 8'h0f

// request lengths in bytes, check bytes included
`define TCE_LEN_SHORT 3'd3
`define TCE_LEN_LONG 3'd4
`define TCE_LEN_MAX 3'd7

// reply payload lengths in bytes
`define TCE_REPLY_HANDLE 3'd1
`define TCE_REPLY_BLOCK 3'd4

// block address limits
`define TCE_ADDR_LAST_USER 8'h7f
`define TCE_ADDR_SYSTEM 8'hff

// check value arithmetic, reflected, low byte first
`define TCE_CRC_INIT 16'hffff
`define TCE_CRC_POLY 16'h8408
`define TCE_CRC_RESIDUE 16'hf0b8

// free-running generator
`define TCE_LFSR_SEED 16'hace1
`define TCE_LFSR_TAPS 16'hb400

`endif

// >>> include/tce_pkg.sv
// types and shared arithmetic of the tag command engine
`include "tce_map.svh"

package tce_pkg;

    // tag states, gray along ready, inventory, selected, deselected, deactivated
    typedef enum logic [2:0] {
        TCE_READY = 3'b000,
        TCE_INVENTORY = 3'b001,
        TCE_SELECTED = 3'b011,
        TCE_DESELECTED = 3'b010,
        TCE_DEACTIVATED = 3'b110
    } tce_state_e;

    // one byte through the check value, least significant bit first
    function automatic logic [15:0] tce_crc_byte(input logic [15:0] crc, input logic [7:0] data);
        logic [15:0] c;
        c = crc ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ `TCE_CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

endpackage

// >>> src/tce_rx_link.sv
// link-side request frame collector with check value test
`timescale 1ns/1ps
`default_nettype none
`include "tce_map.svh"

module tce_rx_link
    import tce_pkg::*;
(
    input wire logic i_lclk,
    input wire logic i_lrst,
    input wire logic i_valid,
    input wire logic [7:0] i_byte,
    input wire logic i_eof,
    output logic o_tgl,
    output logic [7:0] o_cmd,
    output logic [7:0] o_p1,
    output logic [2:0] o_len
);

    logic [2:0] cnt;
    logic [15:0] crc;
    logic [7:0] b0;
    logic [7:0] b1;

    // frame is good when sized right and residue matches
    wire len_ok = (cnt == `TCE_LEN_SHORT) || (cnt == `TCE_LEN_LONG);
    wire crc_ok = (crc == `TCE_CRC_RESIDUE);

    // collect bytes, hand a good frame over by toggle
    always_ff @(posedge i_lclk) begin
        if (i_lrst) begin
            cnt <= 3'd0;
            crc <= `TCE_CRC_INIT;
            b0 <= 8'h00;
            b1 <= 8'h00;
            o_tgl <= 1'b0;
            o_cmd <= 8'h00;
            o_p1 <= 8'h00;
            o_len <= 3'd0;
        end else if (i_eof) begin
            if (len_ok && crc_ok) begin
                o_cmd <= b0;
                o_p1 <= b1;
                o_len <= cnt;
                o_tgl <= ~o_tgl;
            end
            cnt <= 3'd0;
            crc <= `TCE_CRC_INIT;
        end else if (i_valid) begin
            crc <= tce_crc_byte(crc, i_byte);
            if (cnt == 3'd0) b0 <= i_byte;
            if (cnt == 3'd1) b1 <= i_byte;
            if (cnt != `TCE_LEN_MAX) cnt <= cnt + 3'd1;
        end
    end

endmodule // tce_rx_link

`default_nettype wire

// >>> src/tce_tx_link.sv
// link-side reply serialiser appending the check value
`timescale 1ns/1ps
`default_nettype none
`include "tce_map.svh"

module tce_tx_link
    import tce_pkg::*;
(
    input wire logic i_lclk,
    input wire logic i_lrst,
    input wire logic i_tgl,
    input wire logic [31:0] i_payload,
    input wire logic [2:0] i_len,
    input wire logic i_ready,
    output logic o_valid,
    output logic [7:0] o_byte,
    output logic o_last
);

    logic tgl_meta;
    logic tgl_sync;
    logic tgl_seen;
    logic busy;
    logic [2:0] idx;
    logic [15:0] crc;

    // byte to present next: payload, then check low, then check high
    wire start = tgl_sync ^ tgl_seen;
    wire in_data = idx < i_len;
    wire [7:0] data_byte = in_data ? i_payload[{idx[1:0], 3'b000} +: 8]
        : (idx == i_len) ? ~crc[7:0] : ~crc[15:8];
    wire is_last = (idx == i_len + 3'd1);
    wire advance = busy && (!o_valid || i_ready);

    // start toggle crossing
    always_ff @(posedge i_lclk) begin
        if (i_lrst) begin
            tgl_meta <= 1'b0;
            tgl_sync <= 1'b0;
        end else begin
            tgl_meta <= i_tgl;
            tgl_sync <= tgl_meta;
        end
    end

    // serialise low byte first, each byte taken whole
    always_ff @(posedge i_lclk) begin
        if (i_lrst) begin
            tgl_seen <= 1'b0;
            busy <= 1'b0;
            idx <= 3'd0;
            crc <= `TCE_CRC_INIT;
            o_valid <= 1'b0;
            o_byte <= 8'h00;
            o_last <= 1'b0;
        end else begin
            if (o_valid && i_ready) o_valid <= 1'b0;
            if (advance) begin
                o_valid <= 1'b1;
                o_byte <= data_byte;
                o_last <= is_last;
                if (in_data) crc <= tce_crc_byte(crc, data_byte);
                idx <= idx + 3'd1;
                if (is_last) busy <= 1'b0;
            end else if (!busy && start) begin
                tgl_seen <= tgl_sync;
                busy <= 1'b1;
                idx <= 3'd0;
                crc <= `TCE_CRC_INIT;
            end
        end
    end

endmodule // tce_tx_link

`default_nettype wire

// >>> src/tce_engine.sv
// command decoder and state machine of the contactless tag
`timescale 1ns/1ps
`default_nettype none
`include "tce_map.svh"

module tce_engine
    import tce_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_lclk,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_byte,
    input wire logic i_rx_eof,
    input wire logic i_tx_ready,
    input wire logic [31:0] i_mem_data,
    output logic o_tx_valid,
    output logic [7:0] o_tx_byte,
    output logic o_tx_last,
    output logic o_mem_rd,
    output logic [7:0] o_mem_addr,
    output logic [2:0] o_state,
    output logic [7:0] o_handle
);

    // link-domain reset, released on the link clock
    logic lrst_meta;
    logic lrst;

    // request hand-over from the link side
    logic rx_tgl;
    logic [7:0] rx_cmd;
    logic [7:0] rx_p1;
    logic [2:0] rx_len;
    logic req_meta;
    logic req_sync;
    logic req_seen;

    // tag state and random source
    tce_state_e state;
    tce_state_e next_state;
    logic [15:0] lfsr;
    logic [7:0] handle;
    logic [7:0] next_handle;

    // reply launch towards the link side
    logic tx_tgl;
    logic [31:0] tx_payload;
    logic [2:0] tx_len;
    logic fetch_wait;

    // link reset synchroniser
    always_ff @(posedge i_lclk) begin
        lrst_meta <= i_rst;
        lrst <= lrst_meta;
    end

    // request frame collector on the link clock
    tce_rx_link u_rx (
        .i_lclk(i_lclk),
        .i_lrst(lrst),
        .i_valid(i_rx_valid),
        .i_byte(i_rx_byte),
        .i_eof(i_rx_eof),
        .o_tgl(rx_tgl),
        .o_cmd(rx_cmd),
        .o_p1(rx_p1),
        .o_len(rx_len)
    );

    // reply serialiser on the link clock
    tce_tx_link u_tx (
        .i_lclk(i_lclk),
        .i_lrst(lrst),
        .i_tgl(tx_tgl),
        .i_payload(tx_payload),
        .i_len(tx_len),
        .i_ready(i_tx_ready),
        .o_valid(o_tx_valid),
        .o_byte(o_tx_byte),
        .o_last(o_tx_last)
    );

    // request toggle crossing into the core clock
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            req_meta <= 1'b0;
            req_sync <= 1'b0;
        end else begin
            req_meta <= rx_tgl;
            req_sync <= req_meta;
        end
    end

    // new frame seen; its fields stay still until the next frame ends
    wire new_frame = req_sync ^ req_seen;

    // command decode
    wire is_long = (rx_len == `TCE_LEN_LONG);
    wire is_short = (rx_len == `TCE_LEN_SHORT);
    wire is_inv = is_long && (rx_cmd == `TCE_CMD_INVENTORY);
    wire is_open = is_inv && (rx_p1 == `TCE_SUB_OPEN);
    wire is_poll = is_inv && (rx_p1 == `TCE_SUB_POLL);
    wire [3:0] probe_slot_index = rx_cmd[7:4];
    wire is_probe = is_short && (rx_cmd[3:0] == `TCE_PROBE_CODE)
        && (probe_slot_index != 4'h0);
    wire is_select = is_long && (rx_cmd == `TCE_CMD_SELECT);
    wire is_finish = is_short && (rx_cmd == `TCE_CMD_FINISH);
    wire is_census = is_short && (rx_cmd == `TCE_CMD_CENSUS);
    wire is_fetch = is_long && (rx_cmd == `TCE_CMD_FETCH);

    // state qualifiers
    wire in_ready = (state == TCE_READY);
    wire in_inv = (state == TCE_INVENTORY);
    wire in_sel = (state == TCE_SELECTED);
    wire in_desel = (state == TCE_DESELECTED);

    // slot held in the low nibble of the handle
    wire [3:0] tag_random_slot = handle[3:0];
    wire [3:0] fresh_slot = lfsr[3:0];
    wire handle_match = (rx_p1 == handle);
    wire addr_ok = (rx_p1 <= `TCE_ADDR_LAST_USER)
        || (rx_p1 == `TCE_ADDR_SYSTEM);

    // accepted actions; ready only obeys open, deactivated obeys nothing
    wire do_open = new_frame && is_open && in_ready;
    wire do_poll = new_frame && is_poll && in_inv;
    wire do_probe = new_frame && is_probe && in_inv;
    wire can_select = in_inv || in_sel || in_desel;
    wire do_select = new_frame && is_select && can_select && handle_match;
    wire do_drop = new_frame && is_select && in_sel && !handle_match;
    wire do_finish = new_frame && is_finish && in_sel;
    wire do_census = new_frame && is_census && in_sel;
    wire do_fetch = new_frame && is_fetch && in_sel && addr_ok;

    // replies that carry the handle
    wire poll_hit = do_poll && (fresh_slot == 4'h0);
    wire probe_hit = do_probe && (probe_slot_index == tag_random_slot);
    wire reply_handle = do_open || poll_hit || probe_hit || do_select;

    // next state
    always_comb begin
        next_state = state;
        case (state)
            TCE_READY: begin
                if (do_open) next_state = TCE_INVENTORY;
            end
            TCE_INVENTORY: begin
                if (do_select) next_state = TCE_SELECTED;
            end
            TCE_SELECTED: begin
                if (do_finish) begin
                    next_state = TCE_DEACTIVATED;
                end else if (do_census) begin
                    next_state = TCE_INVENTORY;
                end else if (do_drop) begin
                    next_state = TCE_DESELECTED;
                end
            end
            TCE_DESELECTED: begin
                if (do_select) next_state = TCE_SELECTED;
            end
            TCE_DEACTIVATED: begin
                next_state = TCE_DEACTIVATED;
            end
            default: begin
                next_state = TCE_READY;
            end
        endcase
    end

    // next handle: full draw on open, slot draw on poll, else kept
    always_comb begin
        next_handle = handle;
        if (do_open) begin
            next_handle = lfsr[7:0];
        end else if (do_poll) begin
            next_handle = {handle[7:4], fresh_slot};
        end
    end

    // free-running galois generator, never held or reset to zero
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            lfsr <= `TCE_LFSR_SEED;
        end else begin
            lfsr <= lfsr[0] ? ((lfsr >> 1) ^ `TCE_LFSR_TAPS) : (lfsr >> 1);
        end
    end

    // tag state and handle
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state <= TCE_READY;
            handle <= 8'h00;
            req_seen <= 1'b0;
        end else begin
            state <= next_state;
            handle <= next_handle;
            req_seen <= req_sync;
        end
    end

    // block read request, data arrives one cycle later
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_mem_rd <= 1'b0;
            o_mem_addr <= 8'h00;
            fetch_wait <= 1'b0;
        end else begin
            o_mem_rd <= do_fetch;
            fetch_wait <= o_mem_rd;
            if (do_fetch) o_mem_addr <= rx_p1;
        end
    end

    // reply launch: handle byte or the four block bytes
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            tx_tgl <= 1'b0;
            tx_payload <= 32'h0000_0000;
            tx_len <= 3'd0;
        end else if (reply_handle) begin
            tx_payload <= {24'h00_0000, next_handle};
            tx_len <= `TCE_REPLY_HANDLE;
            tx_tgl <= ~tx_tgl;
        end else if (fetch_wait) begin
            tx_payload <= i_mem_data;
            tx_len <= `TCE_REPLY_BLOCK;
            tx_tgl <= ~tx_tgl;
        end
    end

    // observation outputs from flops
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_state <= TCE_READY;
            o_handle <= 8'h00;
        end else begin
            o_state <= next_state;
            o_handle <= next_handle;
        end
    end

endmodule // tce_engine

`default_nettype wire

// >>> sim/tce_engine_sva.sv
// checker of the tag command engine ports
`timescale 1ns/1ps
`default_nettype none
module tce_engine_sva
    import tce_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_lclk,
    input wire logic i_tx_ready,
    input wire logic o_tx_valid,
    input wire logic [7:0] o_tx_byte,
    input wire logic o_tx_last,
    input wire logic o_mem_rd,
    input wire logic [7:0] o_mem_addr,
    input wire logic [2:0] o_state,
    input wire logic [7:0] o_handle
);
    // fetch issued and reply stalled by the reader
    sequence s_fetch_issued;
        o_mem_rd && o_state == TCE_SELECTED;
    endsequence
    sequence s_tx_stall;
        o_tx_valid && !i_tx_ready;
    endsequence

    fetch_state_a:
    assert property (@(posedge i_mclk) disable iff (i_rst) o_mem_rd |-> o_state == TCE_SELECTED)
        else $error("fetch outside selected state");
    fetch_range_a:
    assert property (@(posedge i_mclk) disable iff (i_rst)
        o_mem_rd |-> (o_mem_addr <= 8'h7f || o_mem_addr == 8'hff))
        else $error("fetch of unserved address");
    fetch_pulse_a:
    assert property (@(posedge i_mclk) disable iff (i_rst) s_fetch_issued |=> !o_mem_rd)
        else $error("memory read not a single pulse");
    tx_hold_a:
    assert property (@(posedge i_lclk) disable iff (i_rst)
        s_tx_stall |=> o_tx_valid && $stable(o_tx_byte) && $stable(o_tx_last))
        else $error("reply byte dropped while stalled");
    deact_hold_a:
    assert property (@(posedge i_mclk) disable iff (i_rst)
        o_state == TCE_DEACTIVATED |=> o_state == TCE_DEACTIVATED)
        else $error("left deactivated state");
    deact_entry_a:
    assert property (@(posedge i_mclk) disable iff (i_rst)
        $changed(o_state) && o_state == TCE_DEACTIVATED |-> $past(o_state) == TCE_SELECTED)
        else $error("deactivated from wrong state");
    sel_entry_a:
    assert property (@(posedge i_mclk) disable iff (i_rst)
        o_state == TCE_SELECTED && $past(o_state) != TCE_SELECTED
        |-> $past(o_state) inside {TCE_INVENTORY, TCE_DESELECTED})
        else $error("selected from wrong state");
    census_entry_a:
    assert property (@(posedge i_mclk) disable iff (i_rst)
        o_state == TCE_INVENTORY && $past(o_state) != TCE_INVENTORY
        |-> $past(o_state) inside {TCE_READY, TCE_SELECTED})
        else $error("inventory from wrong state");
    ready_exit_a:
    assert property (@(posedge i_mclk) disable iff (i_rst)
        $past(o_state) == TCE_READY && o_state != TCE_READY |-> o_state == TCE_INVENTORY)
        else $error("ready left to wrong state");
    handle_keep_a:
    assert property (@(posedge i_mclk) disable iff (i_rst)
        $changed(o_handle) |-> $past(o_state) inside {TCE_READY, TCE_INVENTORY})
        else $error("handle changed outside census");
endmodule // tce_engine_sva
`default_nettype wire

// >>> sim/tce_reader.sv
// reader model sending request frames and gathering replies
`timescale 1ns/1ps
`default_nettype none
module tce_reader (
    input wire logic i_lclk,
    output logic o_valid,
    output logic [7:0] o_byte,
    output logic o_eof,
    output logic o_ready,
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_byte,
    input wire logic i_tx_last
);
    logic [7:0] rx[$]; // reply bytes of the last frame
    logic crc_ok; // reply check value good
    logic got_last; // last reply byte carried the end marker

    // idle link at time zero
    initial begin
        o_valid = 1'b0;
        o_byte = 8'h00;
        o_eof = 1'b0;
        o_ready = 1'b0;
        crc_ok = 1'b0;
        got_last = 1'b0;
    end

    // one byte through the check value, lsb first
    function automatic logic [15:0] crc_add(input logic [15:0] c, input logic [7:0] d);
        c = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
        end
        return c;
    endfunction

    // send bytes plus check value, then collect the reply
    task automatic frame(input logic [7:0] b[$], input bit bad, input bit slow);
        logic [15:0] c;
        int n;
        c = 16'hffff;
        foreach (b[i]) c = crc_add(c, b[i]);
        c = ~c;
        b.push_back(c[7:0]);
        b.push_back(bad ? ~c[15:8] : c[15:8]);
        rx.delete();
        foreach (b[i]) begin
            @(posedge i_lclk);
            #1;
            o_valid = 1'b1;
            o_byte = b[i];
        end
        @(posedge i_lclk);
        #1;
        o_valid = 1'b0;
        o_byte = ~o_byte; // no stale byte on a released line
        o_eof = 1'b1;
        @(posedge i_lclk);
        #1;
        o_eof = 1'b0;
        c = 16'hffff;
        n = 0;
        got_last = 1'b0;
        while (n < 60) begin
            o_ready = !slow || n[0]; // slow reader stalls every other cycle
            @(posedge i_lclk);
            n++;
            if (i_tx_valid && o_ready) begin
                rx.push_back(i_tx_byte);
                c = crc_add(c, i_tx_byte);
                got_last = i_tx_last;
                if (i_tx_last) n = 99;
            end
            #1;
        end
        o_ready = 1'b0;
        crc_ok = (c == 16'hf0b8);
    endtask
endmodule // tce_reader
`default_nettype wire

// >>> sim/testbench.sv
// testbench of the tag command engine
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tce_pkg::*;
    logic i_mclk = 1'b0;
    logic i_lclk = 1'b0;
    logic i_rst = 1'b1;
    logic [31:0] i_mem_data = 32'h0;
    logic rx_valid, rx_eof, tx_ready, tx_valid, tx_last, mem_rd;
    logic [7:0] rx_byte, tx_byte, mem_addr, o_handle;
    logic [2:0] o_state;
    int compares = 0;
    int miscompares = 0;

    // core clock and an unrelated link clock
    always #2.5 i_mclk = ~i_mclk;
    always #6 i_lclk = ~i_lclk;

    // block memory, one cycle latency, noise when idle
    always @(posedge i_mclk) begin
        i_mem_data <= mem_rd ? {~mem_addr, mem_addr ^ 8'h3c, 8'ha5, mem_addr} : ~i_mem_data;
    end

    tce_engine uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_lclk(i_lclk), .i_rx_valid(rx_valid),
        .i_rx_byte(rx_byte), .i_rx_eof(rx_eof), .i_tx_ready(tx_ready),
        .i_mem_data(i_mem_data), .o_tx_valid(tx_valid), .o_tx_byte(tx_byte),
        .o_tx_last(tx_last), .o_mem_rd(mem_rd), .o_mem_addr(mem_addr), .o_state(o_state),
        .o_handle(o_handle));
    tce_reader rd (.i_lclk(i_lclk), .o_valid(rx_valid), .o_byte(rx_byte), .o_eof(rx_eof),
        .o_ready(tx_ready), .i_tx_valid(tx_valid), .i_tx_byte(tx_byte), .i_tx_last(tx_last));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic send(input logic [7:0] b[$], input bit bad, input bit slow);
        rd.frame(b, bad, slow);
        if (rd.rx.size() > 0) begin
            chk({rd.crc_ok, rd.got_last}, 2'b11);
        end
    endtask

    task automatic t_before_open;
        chk(o_state, TCE_READY);
        send('{8'h0e, 8'h00}, 0, 0);
        chk(rd.rx.size(), 0);
        send('{8'h06, 8'h04}, 0, 0);
        chk(rd.rx.size(), 0);
        send('{8'h08, 8'h00}, 0, 0);
        chk(rd.rx.size(), 0);
        chk(o_state, TCE_READY);
    endtask

    task automatic t_open;
        logic [7:0] h;
        send('{8'h06, 8'h00}, 0, 0);
        chk(rd.rx[0], o_handle);
        chk(o_state, TCE_INVENTORY);
        h = o_handle;
        send('{8'h06, 8'h04}, 1, 0);
        chk(rd.rx.size(), 0);
        chk(o_handle, h);
    endtask

    task automatic t_slots;
        logic [7:0] h;
        logic [3:0] s;
        for (int k = 0; k < 4; k++) begin
            h = o_handle;
            send('{8'h06, 8'h04}, 0, 0);
            s = o_handle[3:0];
            chk(o_handle[7:4], h[7:4]);
            chk(rd.rx.size(), (s == 4'h0) ? 3 : 0);
            if (s != 4'h0) begin
                send('{{s, 4'h6}}, 0, 0);
                chk(rd.rx[0], o_handle);
                send('{{(s == 4'hf ? 4'h1 : s + 4'h1), 4'h6}}, 0, 0);
                chk(rd.rx.size(), 0);
                chk(o_handle[3:0], s);
            end
        end
    endtask

    task automatic t_select;
        logic [7:0] h;
        logic [7:0] a;
        logic [7:0] good[3] = '{8'h00, 8'h7f, 8'hff};
        logic [7:0] bad[2] = '{8'h80, 8'hfe};
        h = o_handle;
        send('{8'h0e, ~h}, 0, 0);
        chk(o_state, TCE_INVENTORY);
        send('{8'h0e, h}, 0, 0);
        chk(rd.rx[0], h);
        chk(o_state, TCE_SELECTED);
        foreach (good[i]) begin
            a = good[i];
            send('{8'h08, a}, 0, 1);
            chk({rd.rx[3], rd.rx[2], rd.rx[1], rd.rx[0]}, {~a, a ^ 8'h3c, 8'ha5, a});
        end
        foreach (bad[i]) begin
            send('{8'h08, bad[i]}, 0, 0);
            chk(rd.rx.size(), 0);
        end
        send('{8'h0e, ~h}, 0, 0);
        chk(o_state, TCE_DESELECTED);
        send('{8'h08, 8'h01}, 0, 0);
        chk(rd.rx.size(), 0);
        send('{8'h0f}, 0, 0);
        chk(o_state, TCE_DESELECTED);
        send('{8'h0e, h}, 0, 0);
        send('{8'h0c}, 0, 0);
        chk(rd.rx.size(), 0);
        chk(o_state, TCE_INVENTORY);
        send('{8'h06, 8'h04}, 0, 0);
        chk(o_handle[7:4], h[7:4]);
        chk(rd.rx.size(), (o_handle[3:0] == 4'h0) ? 3 : 0);
        h = o_handle;
        send('{8'h0f}, 0, 0);
        chk(o_state, TCE_INVENTORY);
        send('{8'h0e, h}, 0, 0);
        send('{8'h0f}, 0, 0);
        chk(rd.rx.size(), 0);
        chk(o_state, TCE_DEACTIVATED);
        send('{8'h0e, h}, 0, 0);
        chk(rd.rx.size(), 0);
    endtask

    // field loss in mid-run: only a reset leaves deactivated
    task automatic t_field_loss;
        @(posedge i_mclk);
        #1;
        i_rst = 1'b1;
        repeat (8) @(posedge i_lclk);
        @(posedge i_mclk);
        #1;
        i_rst = 1'b0;
        repeat (4) @(posedge i_lclk);
        chk(o_state, TCE_READY);
        send('{8'h06, 8'h00}, 0, 0);
        chk(rd.rx.size(), 3);
        chk(o_state, TCE_INVENTORY);
    endtask

    // reset, then the scenarios in turn
    initial begin
        repeat (8) @(posedge i_lclk);
        @(posedge i_mclk);
        #1;
        i_rst = 1'b0;
        repeat (4) @(posedge i_lclk);
        t_before_open();
        t_open();
        t_slots();
        t_select();
        t_field_loss();
        complete_run();
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge i_mclk);
        miscompares++;
        complete_run();
    end
endmodule // testbench

bind tce_engine tce_engine_sva chk_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_lclk(i_lclk),
    .i_tx_ready(i_tx_ready), .o_tx_valid(o_tx_valid), .o_tx_byte(o_tx_byte),
    .o_tx_last(o_tx_last), .o_mem_rd(o_mem_rd), .o_mem_addr(o_mem_addr),
    .o_state(o_state), .o_handle(o_handle));
`default_nettype wire
